// ### design/sdram_cmd_consts.vh
`ifndef SDRAM_CMD_CONSTS_VH
`define SDRAM_CMD_CONSTS_VH

// command codes on {row strobe, column strobe, write strobe}, all low active
`define CMD_MODE_LOAD      3'h0
`define CMD_REFRESH        3'h1
`define CMD_PRECHARGE      3'h2
`define CMD_ACTIVATE       3'h3
`define CMD_WRITE          3'h4
`define CMD_READ           3'h5
`define CMD_CALIBRATE      3'h6
`define CMD_NOP            3'h7

// address bit positions with a second meaning
`define AUTO_CLOSE_BIT     10
`define CHOP_SELECT_BIT    12

// mode register zero: burst length field, code 1 means chop on the fly
`define MR0_BL_LSB         0
`define MR0_BL_MSB         1
`define MR0_BL_ON_THE_FLY  2'h1

// mode register one: termination value bits and strobe repurpose bit
`define MR1_RTT_BIT0       2
`define MR1_RTT_BIT1       6
`define MR1_RTT_BIT2       9
`define MR1_TERM_STROBE    11

// reset contents of every mode register
`define MODE_REG_RESET     15'h0000

// power states
`define PWR_ACTIVE         2'h0
`define PWR_PRE_DOWN       2'h1
`define PWR_ACT_DOWN       2'h2
`define PWR_SELF_REFRESH   2'h3

// bank count and bank address width
`define BANK_COUNT         8
`define BANK_ADDR_W        3

`endif

// ### design/reset_sync.v
`timescale 1ns/1ps

module reset_sync (
    // clock and raw reset
    input  wire clock,
    input  wire rstn,
    // released copy
    output wire rstn_sync
);

    reg stage1_reg;
    reg stage2_reg;

    // assert at once, release after two edges to avoid metastable release
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    assign rstn_sync = stage2_reg;

endmodule

// ### design/bank_state_track.v
`timescale 1ns/1ps
`include "sdram_cmd_consts.vh"

module bank_state_track #(
    parameter BANKS = `BANK_COUNT
) (
    // clock and reset
    input  wire                     clock,
    input  wire                     rstn,
    // decoded command
    input  wire                     open_cmd,
    input  wire                     close_cmd,
    input  wire                     close_all,
    input  wire [`BANK_ADDR_W-1:0]  bank_sel,
    // bank status
    output wire [BANKS-1:0]         bank_open,
    output wire                     any_open
);

    reg [BANKS-1:0] open_reg;

    // one open flag per bank, all closed after reset
    genvar b;
    generate
        for (b = 0; b < BANKS; b = b + 1) begin : g_bank
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    open_reg[b] <= 1'b0;
                end else if (open_cmd && bank_sel == b) begin
                    open_reg[b] <= 1'b1;
                end else if (close_cmd && (close_all || bank_sel == b)) begin
                    open_reg[b] <= 1'b0;
                end
            end
        end
    endgenerate

    assign bank_open = open_reg;
    assign any_open  = |open_reg;

endmodule

// ### design/sdram_command_pin_decode.v
`timescale 1ns/1ps
`include "sdram_cmd_consts.vh"

module sdram_command_pin_decode #(
    parameter ADDR_W = 15,
    parameter DATA_W = 8,
    parameter IS_X8  = 1
) (
    // clock and reset
    input  wire                    clock,
    input  wire                    rstn,
    // command pins
    input  wire                    cs_n,
    input  wire                    ras_n,
    input  wire                    cas_n,
    input  wire                    we_n,
    input  wire [`BANK_ADDR_W-1:0] bank_addr,
    input  wire [ADDR_W-1:0]       addr,
    input  wire                    cke,
    input  wire                    termination_enable,
    // write data beats
    input  wire [DATA_W-1:0]       wr_data,
    input  wire                    wr_beat_valid,
    input  wire                    write_byte_mask,
    // decoded command strobes
    output reg                     act_strobe,
    output reg                     read_strobe,
    output reg                     write_strobe,
    output reg                     close_strobe,
    output reg                     mode_load_strobe,
    output reg                     refresh_strobe,
    // decoded command fields
    output reg  [`BANK_ADDR_W-1:0] cmd_bank,
    output reg  [ADDR_W-1:0]       row_addr,
    output reg  [ADDR_W-1:0]       col_addr,
    output reg                     auto_close,
    output reg                     burst_eight,
    output reg                     close_all,
    output reg  [1:0]              mode_sel,
    // mode register contents
    output wire [ADDR_W-1:0]       mode_reg_zero,
    output wire [ADDR_W-1:0]       mode_reg_one,
    output wire [ADDR_W-1:0]       mode_reg_two,
    output wire [ADDR_W-1:0]       mode_reg_three,
    // device status
    output wire [`BANK_COUNT-1:0]  bank_open,
    output reg  [1:0]              power_state,
    output reg                     termination_on,
    // accepted write data
    output reg  [DATA_W-1:0]       wr_data_out,
    output reg                     wr_data_out_valid,
    // repurposed mask pin
    output reg                     term_strobe_out
);

    localparam ST_ACTIVE = `PWR_ACTIVE;
    localparam ST_PDN_PRE = `PWR_PRE_DOWN;
    localparam ST_PDN_ACT = `PWR_ACT_DOWN;
    localparam ST_SREF = `PWR_SELF_REFRESH;

    wire                    rst_n_int;
    // registered pin copies
    reg                     cs_n_reg;
    reg  [2:0]              strobes_reg;
    reg  [`BANK_ADDR_W-1:0] bank_reg;
    reg  [ADDR_W-1:0]       addr_reg;
    reg                     cke_reg;
    reg                     cke_prev_reg;
    reg                     term_en_reg;
    reg  [DATA_W-1:0]       data_reg;
    reg                     beat_valid_reg;
    reg                     mask_reg;
    // mode registers
    reg  [ADDR_W-1:0]       mode_mem [0:3];
    // power state machine
    reg  [1:0]              state_next;
    // decode terms
    wire                    decode_en;
    wire                    is_act;
    wire                    is_read;
    wire                    is_write;
    wire                    is_close;
    wire                    is_mode;
    wire                    is_refresh;
    wire                    any_open;
    wire                    chop_on_fly;
    wire                    term_allowed;
    wire                    strobe_mode;
    wire                    mask_usable;
    wire                    sref_entry;
    integer                 i;

    // async assert, two-flop release
    reset_sync u_reset_sync (
        .clock     (clock),
        .rstn      (rstn),
        .rstn_sync (rst_n_int)
    );

    // capture every pin on the rising crossing; idle chip select is high
    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            cs_n_reg       <= 1'b1;
            strobes_reg    <= `CMD_NOP;
            bank_reg       <= {`BANK_ADDR_W{1'b0}};
            addr_reg       <= {ADDR_W{1'b0}};
            cke_reg        <= 1'b0;
            cke_prev_reg   <= 1'b0;
            term_en_reg    <= 1'b0;
            data_reg       <= {DATA_W{1'b0}};
            beat_valid_reg <= 1'b0;
            mask_reg       <= 1'b0;
        end else begin
            cs_n_reg       <= cs_n;
            strobes_reg    <= {ras_n, cas_n, we_n};
            bank_reg       <= bank_addr;
            addr_reg       <= addr;
            cke_reg        <= cke;
            cke_prev_reg   <= cke_reg;
            term_en_reg    <= termination_enable;
            data_reg       <= wr_data;
            beat_valid_reg <= wr_beat_valid;
            mask_reg       <= write_byte_mask;
        end
    end

    // decoder runs only while awake, clock enabled and selected
    assign decode_en  = (power_state == ST_ACTIVE) && cke_reg && !cs_n_reg;
    assign is_act     = decode_en && strobes_reg == `CMD_ACTIVATE;
    assign is_read    = decode_en && strobes_reg == `CMD_READ;
    assign is_write   = decode_en && strobes_reg == `CMD_WRITE;
    assign is_close   = decode_en && strobes_reg == `CMD_PRECHARGE;
    assign is_mode    = decode_en && strobes_reg == `CMD_MODE_LOAD;
    assign is_refresh = decode_en && strobes_reg == `CMD_REFRESH;

    // refresh issued with clock enable just dropped enters self refresh
    assign sref_entry = (power_state == ST_ACTIVE) && !cs_n_reg && cke_prev_reg &&
                        !cke_reg && strobes_reg == `CMD_REFRESH;

    // mode register fields steering the decoder
    assign chop_on_fly  = mode_mem[0][`MR0_BL_MSB:`MR0_BL_LSB] == `MR0_BL_ON_THE_FLY;
    assign term_allowed = mode_mem[1][`MR1_RTT_BIT0] | mode_mem[1][`MR1_RTT_BIT1] |
                          mode_mem[1][`MR1_RTT_BIT2];
    assign strobe_mode  = (IS_X8 != 0) && mode_mem[1][`MR1_TERM_STROBE];
    assign mask_usable  = !strobe_mode;

    // per-bank open/closed tracking
    bank_state_track #(
        .BANKS (`BANK_COUNT)
    ) u_bank_track (
        .clock     (clock),
        .rstn      (rst_n_int),
        .open_cmd  (is_act),
        .close_cmd (is_close),
        .close_all (addr_reg[`AUTO_CLOSE_BIT]),
        .bank_sel  (bank_reg),
        .bank_open (bank_open),
        .any_open  (any_open)
    );

    // power states; bank state at entry picks which power-down
    always @* begin
        state_next = power_state;
        case (power_state)
            ST_ACTIVE: begin
                if (sref_entry) begin
                    state_next = ST_SREF;
                end else if (cke_prev_reg && !cke_reg) begin
                    state_next = any_open ? ST_PDN_ACT : ST_PDN_PRE;
                end
            end
            ST_PDN_PRE, ST_PDN_ACT: begin
                if (cke_reg) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_SREF: begin
                // raw pin, not the registered copy: exit needs no sampled edge
                if (cke) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            power_state <= `PWR_ACTIVE;
        end else begin
            power_state <= state_next;
        end
    end

    // mode register load; bank bit two set is a reserved target and dropped
    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            for (i = 0; i < 4; i = i + 1) begin
                mode_mem[i] <= `MODE_REG_RESET;
            end
        end else if (is_mode && !bank_reg[2]) begin
            mode_mem[bank_reg[1:0]] <= addr_reg;
        end
    end

    assign mode_reg_zero  = mode_mem[0];
    assign mode_reg_one   = mode_mem[1];
    assign mode_reg_two   = mode_mem[2];
    assign mode_reg_three = mode_mem[3];

    // command strobes are one-cycle pulses
    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            act_strobe       <= 1'b0;
            read_strobe      <= 1'b0;
            write_strobe     <= 1'b0;
            close_strobe     <= 1'b0;
            mode_load_strobe <= 1'b0;
            refresh_strobe   <= 1'b0;
        end else begin
            act_strobe       <= is_act;
            read_strobe      <= is_read;
            write_strobe     <= is_write;
            close_strobe     <= is_close;
            mode_load_strobe <= is_mode;
            refresh_strobe   <= is_refresh;
        end
    end

    // command fields hold until the next command that carries them
    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            cmd_bank    <= {`BANK_ADDR_W{1'b0}};
            row_addr    <= {ADDR_W{1'b0}};
            col_addr    <= {ADDR_W{1'b0}};
            auto_close  <= 1'b0;
            burst_eight <= 1'b1;
            close_all   <= 1'b0;
            mode_sel    <= 2'h0;
        end else begin
            if (is_act || is_read || is_write || is_close) begin
                cmd_bank <= bank_reg;
            end
            if (is_act) begin
                row_addr <= addr_reg;
            end
            if (is_read || is_write) begin
                col_addr   <= addr_reg;
                auto_close <= addr_reg[`AUTO_CLOSE_BIT];
                // without on-the-fly chop the burst is always eight
                burst_eight <= chop_on_fly ? addr_reg[`CHOP_SELECT_BIT] : 1'b1;
            end
            if (is_close) begin
                close_all <= addr_reg[`AUTO_CLOSE_BIT];
            end
            if (is_mode) begin
                mode_sel <= bank_reg[1:0];
            end
        end
    end

    // termination follows its pin in power-down too, never in self refresh
    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            termination_on  <= 1'b0;
            term_strobe_out <= 1'b0;
        end else begin
            termination_on  <= term_allowed && term_en_reg &&
                               power_state != ST_SREF;
            term_strobe_out <= strobe_mode && term_allowed && term_en_reg &&
                               power_state != ST_SREF;
        end
    end

    // write beats: dropped while asleep or when the mask is sampled high outside strobe mode
    always @(posedge clock or negedge rst_n_int) begin
        if (!rst_n_int) begin
            wr_data_out       <= {DATA_W{1'b0}};
            wr_data_out_valid <= 1'b0;
        end else begin
            wr_data_out       <= data_reg;
            wr_data_out_valid <= beat_valid_reg && power_state == ST_ACTIVE &&
                                 !(mask_usable && mask_reg);
        end
    end

endmodule

// ### sim/sdram_command_pin_decode_checker.sv
`timescale 1ns/1ps
`include "sdram_cmd_consts.vh"
module sdram_command_pin_decode_checker #(
    parameter ADDR_W = 15,
    parameter DATA_W = 8
) (
    // clock and reset
    input logic                    clock,
    input logic                    rstn,
    // command pins
    input logic                    cs_n,
    input logic                    ras_n,
    input logic                    cas_n,
    input logic                    we_n,
    input logic [`BANK_ADDR_W-1:0] bank_addr,
    input logic [ADDR_W-1:0]       addr,
    input logic                    cke,
    // write beats
    input logic [DATA_W-1:0]       wr_data,
    input logic                    wr_beat_valid,
    input logic                    write_byte_mask,
    // decoder outputs
    input logic                    act_strobe,
    input logic                    read_strobe,
    input logic                    write_strobe,
    input logic                    close_strobe,
    input logic                    mode_load_strobe,
    input logic                    refresh_strobe,
    input logic [`BANK_ADDR_W-1:0] cmd_bank,
    input logic [ADDR_W-1:0]       row_addr,
    input logic [ADDR_W-1:0]       col_addr,
    input logic                    auto_close,
    input logic                    burst_eight,
    input logic                    close_all,
    input logic [1:0]              mode_sel,
    input logic [ADDR_W-1:0]       mode_reg_zero,
    input logic [ADDR_W-1:0]       mode_reg_one,
    input logic [`BANK_COUNT-1:0]  bank_open,
    input logic [1:0]              power_state,
    input logic                    termination_on,
    input logic [DATA_W-1:0]       wr_data_out,
    input logic                    wr_data_out_valid
);
    // command code and the cycles on which the decoder may act
    wire [2:0] cmd     = {ras_n, cas_n, we_n};
    wire       live    = !cs_n && cke && power_state == `PWR_ACTIVE;
    wire       rw      = cmd == `CMD_READ || cmd == `CMD_WRITE;
    wire       strobe  = act_strobe | read_strobe | write_strobe | close_strobe
                         | mode_load_strobe | refresh_strobe;
    wire       rtt_off = !mode_reg_one[2] && !mode_reg_one[6] && !mode_reg_one[9];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // enable seen high, then low on a deselected cycle while awake
    sequence pd_entry;
        cke ##1 (!cke && cs_n && power_state == `PWR_ACTIVE);
    endsequence

    // pins sampled at one edge are registered there and decoded into outputs at the next
    a_row_open: assert property (live && cmd == `CMD_ACTIVATE |-> ##2 act_strobe &&
        row_addr == $past(addr, 2) && cmd_bank == $past(bank_addr, 2) &&
        bank_open[$past(bank_addr, 2)]) else $error("activate fields wrong");
    a_col_fields: assert property (live && rw |-> ##2 (read_strobe != write_strobe) &&
        col_addr == $past(addr, 2) && auto_close == $past(addr[`AUTO_CLOSE_BIT], 2))
        else $error("column fields wrong");
    a_close_scope: assert property (live && cmd == `CMD_PRECHARGE |-> ##2 close_strobe &&
        close_all == $past(addr[`AUTO_CLOSE_BIT], 2)) else $error("precharge scope wrong");
    a_mode_target: assert property (live && cmd == `CMD_MODE_LOAD && !bank_addr[2] |-> ##2
        mode_load_strobe && mode_sel == $past(bank_addr[1:0], 2))
        else $error("mode target wrong");
    a_chop_sample: assert property (live && rw && mode_reg_zero[1:0] == `MR0_BL_ON_THE_FLY
        |-> ##2 burst_eight == $past(addr[`CHOP_SELECT_BIT], 2)) else $error("chop select wrong");
    a_desel_quiet: assert property (cs_n |-> ##2 !strobe)
        else $error("strobe while deselected");
    a_asleep_quiet: assert property (power_state != `PWR_ACTIVE |=> !strobe)
        else $error("strobe while asleep");
    a_pd_enter: assert property (pd_entry |-> ##2 power_state ==
        ($past(bank_open) != 0 ? `PWR_ACT_DOWN : `PWR_PRE_DOWN)) else $error("bad power-down");
    a_sr_exit: assert property (power_state == `PWR_SELF_REFRESH && cke |=>
        power_state == `PWR_ACTIVE) else $error("self refresh exit late");
    a_beat_pass: assert property (wr_beat_valid && !write_byte_mask &&
        power_state == `PWR_ACTIVE |-> ##2 wr_data_out_valid && wr_data_out == $past(wr_data, 2))
        else $error("write beat lost");
    a_term_block: assert property (rtt_off |=> !termination_on)
        else $error("termination while disabled");
endmodule

bind sdram_command_pin_decode sdram_command_pin_decode_checker #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
) chk_inst (.*);

// ### sim/sdram_ctrl_model.sv
`timescale 1ns/1ps
module sdram_ctrl_model (
    // clock
    input  wire        clock,
    // command and address pins
    output reg         cs_n,
    output reg  [2:0]  cmd_n,
    output reg  [2:0]  bank_addr,
    output reg  [14:0] addr,
    output reg         cke,
    output reg         termination_enable,
    // write beat pins
    output reg  [7:0]  wr_data,
    output reg         wr_beat_valid,
    output reg         write_byte_mask
);
    // idle levels from time zero: deselected, clock enabled
    initial begin
        cs_n = 1'b1;
        cmd_n = 3'h7;
        bank_addr = 3'h0;
        addr = 15'h0000;
        cke = 1'b1;
        termination_enable = 1'b0;
        wr_data = 8'h00;
        wr_beat_valid = 1'b0;
        write_byte_mask = 1'b0;
    end

    // one command cycle; on release chip select goes high and command, bank and address lines are inverted so stale values never match
    task cmd(input [2:0] c, input [2:0] b, input [14:0] a, input cs, input ck);
        begin
            @(posedge clock);
            cs_n <= cs;
            cmd_n <= c;
            bank_addr <= b;
            addr <= a;
            cke <= ck;
            @(posedge clock);
            cs_n <= 1'b1;
            cmd_n <= ~c;
            bank_addr <= ~b;
            addr <= ~a;
        end
    endtask

    // one write beat, then the data lines are scrambled
    task beat(input [7:0] d, input m);
        begin
            @(posedge clock);
            wr_data <= d;
            wr_beat_valid <= 1'b1;
            write_byte_mask <= m;
            @(posedge clock);
            wr_data <= ~d;
            wr_beat_valid <= 1'b0;
            write_byte_mask <= ~m;
        end
    endtask

    // termination request level
    task term(input t);
        begin
            @(posedge clock);
            termination_enable <= t;
        end
    endtask
endmodule

// ### sim/sdram_command_pin_decode_tb.sv
`timescale 1ns/1ps
`include "sdram_cmd_consts.vh"
module sdram_command_pin_decode_tb;
    // clock, reset and tallies
    reg         clock = 1'b0;
    reg         rstn  = 1'b0;
    integer     miscompares = 0;
    integer     samples_checked = 0;
    integer     i;
    // pins and decoder outputs
    wire [2:0]  cmd_n, bank_addr, cmd_bank;
    wire [14:0] addr, row_addr, col_addr;
    wire [14:0] mode_reg_zero, mode_reg_one, mode_reg_two, mode_reg_three;
    wire [7:0]  wr_data, wr_data_out, bank_open;
    wire [1:0]  mode_sel, power_state;
    wire        cs_n, cke, termination_enable, wr_beat_valid, write_byte_mask;
    wire        act_strobe, read_strobe, write_strobe, close_strobe;
    wire        mode_load_strobe, refresh_strobe, auto_close, burst_eight;
    wire        close_all, termination_on, wr_data_out_valid, term_strobe_out;
    wire [5:0]  strobes = {act_strobe, read_strobe, write_strobe, close_strobe,
                           mode_load_strobe, refresh_strobe};

    always #2 clock = ~clock;

    sdram_ctrl_model ctrl (.*);
    sdram_command_pin_decode dut (.*, .ras_n(cmd_n[2]), .cas_n(cmd_n[1]), .we_n(cmd_n[0]));

    // compare and tally
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task tick;
        begin
            @(posedge clock);
            #1;
        end
    endtask

    // selected awake command; results settle one edge after sampling
    task go(input [2:0] c, input [2:0] b, input [14:0] a);
        begin
            ctrl.cmd(c, b, a, 1'b0, 1'b1);
            tick;
        end
    endtask

    function [14:0] mr_val(input integer k);
        mr_val = (k == 0) ? 15'h0001 : (k == 1) ? 15'h0004 : (k == 2) ? 15'h2a5a : 15'h1234;
    endfunction

    task t_term_off;
        begin
            ctrl.term(1'b1);
            tick;
            tick;
            chk(termination_on, 1'b0);
        end
    endtask

    // all four mode registers, then an out-of-range select that must be dropped
    task t_modes;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                go(`CMD_MODE_LOAD, i[2:0], mr_val(i));
                chk(strobes, 6'h02);
                chk(mode_sel, i[1:0]);
            end
            go(`CMD_MODE_LOAD, 3'h4, 15'h7fff);
            // the command still decodes; only the register write is dropped
            chk(strobes, 6'h02);
            chk({mode_reg_one, mode_reg_zero}, {15'h0004, 15'h0001});
            chk({mode_reg_three, mode_reg_two}, {15'h1234, 15'h2a5a});
            chk(termination_on, 1'b1);
            ctrl.term(1'b0);
            tick;
            tick;
            chk(termination_on, 1'b0);
        end
    endtask

    task t_rows;
        begin
            go(`CMD_ACTIVATE, 3'h5, 15'h1234);
            chk(strobes, 6'h20);
            chk({cmd_bank, row_addr, bank_open}, {3'h5, 15'h1234, 8'h20});
            go(`CMD_READ, 3'h5, 15'h0477);
            chk(strobes, 6'h10);
            chk({col_addr, auto_close, burst_eight}, {15'h0477, 2'b10});
            go(`CMD_WRITE, 3'h5, 15'h1008);
            chk(strobes, 6'h08);
            chk({col_addr, auto_close, burst_eight}, {15'h1008, 2'b01});
        end
    endtask

    task t_close;
        begin
            go(`CMD_PRECHARGE, 3'h0, 15'h0400);
            chk({strobes, close_all, bank_open}, {6'h04, 1'b1, 8'h00});
            go(`CMD_ACTIVATE, 3'h1, 15'h0000);
            go(`CMD_ACTIVATE, 3'h2, 15'h0000);
            go(`CMD_PRECHARGE, 3'h2, 15'h0000);
            chk({close_all, bank_open}, {1'b0, 8'h02});
        end
    endtask

    // deselected activate is masked; leftover codes decode to nothing
    task t_select;
        begin
            ctrl.cmd(`CMD_ACTIVATE, 3'h6, 15'h0000, 1'b1, 1'b1);
            tick;
            chk({strobes, bank_open}, {6'h00, 8'h02});
            go(`CMD_REFRESH, 3'h0, 15'h0000);
            chk(strobes, 6'h01);
            go(`CMD_CALIBRATE, 3'h0, 15'h0000);
            chk(strobes, 6'h00);
            go(`CMD_NOP, 3'h0, 15'h0000);
            chk(strobes, 6'h00);
        end
    endtask

    task t_power;
        begin
            ctrl.cmd(`CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b0);
            tick;
            chk(power_state, `PWR_ACT_DOWN);
            ctrl.cmd(`CMD_ACTIVATE, 3'h3, 15'h0000, 1'b0, 1'b1);
            tick;
            chk({power_state, strobes}, {`PWR_ACTIVE, 6'h00});
            go(`CMD_PRECHARGE, 3'h0, 15'h0400);
            ctrl.cmd(`CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b0);
            tick;
            chk(power_state, `PWR_PRE_DOWN);
            go(`CMD_NOP, 3'h0, 15'h0000);
            chk(power_state, `PWR_ACTIVE);
            ctrl.cmd(`CMD_REFRESH, 3'h0, 15'h0000, 1'b0, 1'b0);
            tick;
            chk({power_state, strobes}, {`PWR_SELF_REFRESH, 6'h00});
            ctrl.cmd(`CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b1);
            #1;
            chk(power_state, `PWR_ACTIVE);
        end
    endtask

    // plain beat, masked beat, then masking lost to the strobe repurpose
    task t_beats;
        begin
            ctrl.beat(8'ha5, 1'b0);
            tick;
            chk({wr_data_out_valid, wr_data_out}, {1'b1, 8'ha5});
            ctrl.beat(8'h3c, 1'b1);
            tick;
            chk(wr_data_out_valid, 1'b0);
            go(`CMD_MODE_LOAD, 3'h1, 15'h0804);
            ctrl.beat(8'h3c, 1'b1);
            tick;
            chk({wr_data_out_valid, wr_data_out}, {1'b1, 8'h3c});
            ctrl.term(1'b1);
            tick;
            tick;
            chk({term_strobe_out, termination_on}, 2'b11);
        end
    endtask

    // reset lands on a rising edge and acts before the next, with no clock needed
    task t_reset;
        begin
            go(`CMD_ACTIVATE, 3'h4, 15'h0000);
            @(posedge clock);
            rstn <= 1'b0;
            #1;
            chk({bank_open, power_state, burst_eight, mode_reg_one, term_strobe_out},
                {8'h00, `PWR_ACTIVE, 1'b1, 15'h0000, 1'b0});
            repeat (4) @(posedge clock);
            rstn <= 1'b1;
            repeat (4) @(posedge clock);
        end
    endtask

    task finish_test;
        begin
            $display("compares=%0d miscompares=%0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        t_term_off;
        t_modes;
        t_rows;
        t_close;
        t_select;
        t_power;
        t_beats;
        t_reset;
        finish_test;
    end

    // the run needs about 120 cycles; this bound is far beyond it
    initial begin
        #40000;
        miscompares = miscompares + 1;
        finish_test;
    end
endmodule
